// ---- core/csf_defs.vh ----
// Purpose: Constants for the core status flag block.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes:   Offsets are byte addresses.
`ifndef CSF_DEFS_VH
`define CSF_DEFS_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define CSF_OFF_STATUS    8'h00
`define CSF_OFF_OPTION    8'h04
`define CSF_OFF_INTSTAT   8'h08
`define CSF_OFF_INTEN     8'h0C
`define CSF_OFF_INTCLR    8'h10
`define CSF_OFF_TIMER     8'h14
`define CSF_OFF_ALU       8'h18
// ****************************************************************
// Status field positions
// ****************************************************************
`define CSF_B_CARRY       0
`define CSF_B_NIBBLE      1
`define CSF_B_ZERO        2
`define CSF_B_PDOWN       3
`define CSF_B_EXPIRY      4
`define CSF_B_BANK        5
// ****************************************************************
// Option fields and reset values
// ****************************************************************
`define CSF_B_PSA         3
`define CSF_OPTION_RST    8'hFF
`define CSF_BANK0_BASE    8'h00
`define CSF_BANK1_BASE    8'h80
`define CSF_BANK_SIZE     9'h080
// ****************************************************************
// Operation codes on the ALU port
// ****************************************************************
`define CSF_OP_ADD        3'h0
`define CSF_OP_SUB        3'h1
`define CSF_OP_LOGIC      3'h2
`define CSF_OP_ROTL       3'h3
`define CSF_OP_ROTR       3'h4
`define CSF_OP_NONE       3'h7
// ****************************************************************
// Timing: watchdog base divider
// ****************************************************************
`define CSF_WDOG_BASE     16'h0100
`endif

// ---- core/csf_prescaler.v ----
// Purpose: Shared 8-bit prescaler with a rate-select tap.
// Assumes: Tick input is one cycle wide.
// Notes:   Rate select n gives a divide by 2^(n+1).
`timescale 1ns/1ps
module csf_prescaler (
  input  wire       hclk,     // Clock.
  input  wire       hresetn,  // Async reset, active low.
  input  wire       clr,      // Clear count.
  input  wire       tick_in,  // Event to divide.
  input  wire [2:0] rate,     // Rate select.
  output reg        tick_out  // Divided event.
);
  reg [7:0] count;
  wire [7:0] next_count = count + 8'h01;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (clr) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (tick_in) begin
      count    <= next_count;
      // Firing as the tap bit falls gives a full period before the first output.
      tick_out <= count[rate] & ~next_count[rate];
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule

// ---- core/csf_status_top.v ----
// Purpose: Processor status flags, shared prescaler and watchdog over AHB-Lite.
// Assumes: Core pulses are one hclk wide and synchronous to hclk.
// Notes:   Zero-wait-state slave; response is always OKAY.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "csf_defs.vh"
// How it works
// RL1 - Bank field 00 selects 00h-7Fh, 01 selects 80h-FFh, 128 bytes each.
// RL2 - Expiry flag reads 1 after reset, watchdog-clear and sleep.
// RL3 - Expiry flag clears to 0 on a watchdog time-out.
// RL4 - Power-down flag is 1 after reset and after watchdog-clear.
// RL5 - Power-down flag clears to 0 on sleep.
// RL6 - Zero flag follows whether an arithmetic or logic result is zero.
// RL7 - Add and subtract set nibble carry from carry out of bit 3.
// RL8 - Add and subtract set carry from carry out of bit 7.
// RL9 - Subtract adds the two's complement, so carries are inverted borrows.
// RL10 - Rotates load carry with the source high or low bit.
// RL11 - Prescaler serves timer or watchdog, never both; watchdog use gives timer 1:1.
// RL12 - Watchdog keeps its own divider for time-out selection.
// RL13 - Result flags hold unless the operation affects them.
module csf_status_top (
  input  wire        hclk,         // Clock, 200 MHz.
  input  wire        hresetn,      // Async reset, active low.
  input  wire        hsel,         // Slave select.
  input  wire [7:0]  haddr,        // Byte address.
  input  wire [1:0]  htrans,       // Transfer type.
  input  wire        hwrite,       // Write strobe.
  input  wire [2:0]  hsize,        // Transfer size.
  input  wire        hready,       // Bus ready in.
  input  wire [31:0] hwdata,       // Write data.
  output reg  [31:0] hrdata,       // Read data.
  output reg         hreadyout,    // Ready out.
  output reg         hresp,        // Response, always OKAY.
  input  wire        op_valid,     // ALU operation strobe.
  input  wire [2:0]  op_code,      // ALU operation.
  input  wire [7:0]  op_a,         // First operand.
  input  wire [7:0]  op_b,         // Second operand.
  output reg  [7:0]  op_result,    // Registered ALU result.
  input  wire        wdog_clear,   // Watchdog-clear instruction pulse.
  input  wire        sleep_instr,  // Sleep instruction pulse.
  input  wire        ext_tick_pin, // External timer input pin.
  output reg  [7:0]  bank_base,    // Base address of the selected bank.
  output reg         wdog_reset,   // Watchdog time-out pulse.
  output reg         irq           // Level interrupt.
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [1:0]  bank;
  reg        expiry;
  reg        pdown;
  reg        zero_f;
  reg        nib_f;
  reg        carry_f;
  reg [7:0]  option;
  reg [1:0]  int_stat;
  reg [1:0]  int_en;
  reg [7:0]  timer_count;
  reg        wdog_tout;
  reg [15:0] wdog_div;
  reg [1:0]  pin_sync;
  reg        pin_prev;
  reg        ph_write;
  reg        ph_read;
  reg [7:0]  ph_addr;
  reg [7:0]  next_result;
  reg        next_nib;
  reg        next_carry;
  reg        next_affect_c;
  reg [8:0]  sum;
  reg [4:0]  nsum;
  reg [31:0] next_rdata;
  wire [7:0] status_rd;
  wire       take;
  wire       pin_edge;
  wire       pre_to_wdog;
  wire       pre_in;
  wire       pre_out;
  wire       timer_tick;
  wire       wdog_base_tick;
  wire       wdog_fire;
  wire       ovf_ev;
  wire       tout_ev;
  wire       wr_status;
  // Only banks 0 and 1 exist, so the upper select bit is ignored.
  function [7:0] bank_addr;
    input [1:0] sel;
    begin
      bank_addr = sel[0] ? `CSF_BANK1_BASE : `CSF_BANK0_BASE; // see RL1
    end
  endfunction
  assign status_rd = {bank, expiry, pdown, zero_f, nib_f, carry_f};
  assign take = hsel & hready & htrans[1];
  assign wr_status = ph_write && ph_addr == `CSF_OFF_STATUS;
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // The slave never stalls, so hreadyout and hresp keep their reset values.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write  <= 1'b0;
      ph_read   <= 1'b0;
      ph_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_write <= take & hwrite;
      ph_read  <= take & ~hwrite;
      if (take) begin
        ph_addr <= haddr;
      end
    end
  end
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      `CSF_OFF_STATUS:  next_rdata = {24'h000000, status_rd};
      `CSF_OFF_OPTION:  next_rdata = {24'h000000, option};
      `CSF_OFF_INTSTAT: next_rdata = {30'h0000_0000, int_stat};
      `CSF_OFF_INTEN:   next_rdata = {30'h0000_0000, int_en};
      `CSF_OFF_TIMER:   next_rdata = {24'h000000, timer_count};
      `CSF_OFF_ALU:     next_rdata = {24'h000000, op_result};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end
  // Read data is captured in the address phase and stands through the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end
  // ****************************************************************
  // ALU flag logic
  // ****************************************************************
  always @* begin
    sum           = 9'h000;
    nsum          = 5'h00;
    next_result   = op_result;
    next_nib      = nib_f;
    next_carry    = carry_f;
    next_affect_c = 1'b0;
    case (op_code)
      `CSF_OP_ADD: begin
        sum           = {1'b0, op_a} + {1'b0, op_b};
        nsum          = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
        next_result   = sum[7:0];
        next_carry    = sum[8];  // see RL8
        next_nib      = nsum[4]; // see RL7
        next_affect_c = 1'b1;
      end
      `CSF_OP_SUB: begin
        sum           = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001; // see RL9
        nsum          = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01;
        next_result   = sum[7:0];
        next_carry    = sum[8];  // see RL8
        next_nib      = nsum[4]; // see RL7
        next_affect_c = 1'b1;
      end
      `CSF_OP_LOGIC: begin
        next_result = op_a & op_b;
      end
      `CSF_OP_ROTL: begin
        next_result = {op_a[6:0], carry_f};
        next_carry  = op_a[7]; // see RL10
      end
      `CSF_OP_ROTR: begin
        next_result = {carry_f, op_a[7:1]};
        next_carry  = op_a[0]; // see RL10
      end
      default: begin
        next_result = op_result;
      end
    endcase
  end
  // Status writes come first in this block, so an ALU result on the same edge wins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_result <= 8'h00;
      zero_f    <= 1'b0;
      nib_f     <= 1'b0;
      carry_f   <= 1'b0;
      bank      <= 2'h0;
    end else begin
      if (wr_status) begin
        bank    <= {1'b0, hwdata[`CSF_B_BANK]};
        zero_f  <= hwdata[`CSF_B_ZERO];
        nib_f   <= hwdata[`CSF_B_NIBBLE];
        carry_f <= hwdata[`CSF_B_CARRY];
      end
      if (op_valid && op_code != `CSF_OP_NONE) begin // see RL13
        op_result <= next_result;
        // Rotates leave the zero flag alone, and undefined codes move no flag.
        if (op_code == `CSF_OP_ADD || op_code == `CSF_OP_SUB || op_code == `CSF_OP_LOGIC) begin
          zero_f <= (next_result == 8'h00); // see RL6
        end
        if (next_affect_c) begin
          nib_f <= next_nib;
        end
        carry_f <= next_carry;
      end
    end
  end
  // ****************************************************************
  // Watchdog and power flags
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      expiry <= 1'b1; // see RL2
      pdown  <= 1'b1; // see RL4
    end else begin
      // A time-out that meets a clear in one cycle still drops the expiry flag.
      if (wdog_tout) begin
        expiry <= 1'b0; // see RL3
      end else if (wdog_clear | sleep_instr) begin
        expiry <= 1'b1; // see RL2
      end
      if (sleep_instr) begin
        pdown <= 1'b0; // see RL5
      end else if (wdog_clear) begin
        pdown <= 1'b1; // see RL4
      end
    end
  end
  // ****************************************************************
  // Prescaler sharing and timer
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync <= 2'b00;
      pin_prev <= 1'b0;
      option   <= `CSF_OPTION_RST;
    end else begin
      pin_sync <= {pin_sync[0], ext_tick_pin};
      pin_prev <= pin_sync[1];
      if (ph_write && ph_addr == `CSF_OFF_OPTION) begin
        option <= hwdata[7:0];
      end
    end
  end
  // Only the second sync flop feeds the edge detect; the first may be metastable.
  assign pin_edge       = option[4] ? (pin_prev & ~pin_sync[1]) : (~pin_prev & pin_sync[1]);
  // One prescaler serves either the timer or the watchdog. Handing it to the
  // watchdog leaves the timer at one count per source event.
  assign pre_to_wdog    = option[`CSF_B_PSA];
  assign timer_tick     = pre_to_wdog ? (option[5] ? pin_edge : 1'b1) : pre_out; // see RL11
  assign pre_in         = pre_to_wdog ? wdog_base_tick : (option[5] ? pin_edge : 1'b1); // see RL11
  assign wdog_base_tick = (wdog_div == `CSF_WDOG_BASE - 16'h0001); // see RL12
  assign wdog_fire      = pre_to_wdog ? pre_out : wdog_base_tick;
  csf_prescaler u_pre (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clr      (wdog_clear | sleep_instr),
    .tick_in  (pre_in),
    .rate     (option[2:0]),
    .tick_out (pre_out)
  );
  assign ovf_ev  = timer_tick && timer_count == 8'hFF;
  assign tout_ev = wdog_fire;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count <= 8'h00;
      wdog_div    <= 16'h0000;
      wdog_tout   <= 1'b0;
      wdog_reset  <= 1'b0;
      bank_base   <= `CSF_BANK0_BASE;
    end else begin
      if (ph_write && ph_addr == `CSF_OFF_TIMER) begin
        timer_count <= hwdata[7:0];
      end else if (timer_tick) begin
        timer_count <= timer_count + 8'h01;
      end
      // Sleep and clear restart the divider so the next time-out is a full period away.
      if (wdog_clear | sleep_instr | wdog_base_tick) begin
        wdog_div <= 16'h0000;
      end else begin
        wdog_div <= wdog_div + 16'h0001; // see RL12
      end
      wdog_tout  <= tout_ev & ~wdog_clear;
      wdog_reset <= tout_ev & ~wdog_clear;
      bank_base <= bank_addr(bank); // see RL1
    end
  end
  // ****************************************************************
  // Interrupts: sticky status, set wins over clear.
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat <= 2'b00;
      int_en   <= 2'b00;
      irq      <= 1'b0;
    end else begin
      if (ph_write && ph_addr == `CSF_OFF_INTEN) begin
        int_en <= hwdata[1:0];
      end
      if (ph_write && ph_addr == `CSF_OFF_INTCLR) begin
        int_stat <= (int_stat & ~hwdata[1:0]) | {wdog_tout, ovf_ev};
      end else begin
        int_stat <= int_stat | {wdog_tout, ovf_ev};
      end
      // Registered, so irq stands one cycle behind the status and enable bits.
      irq <= |(int_stat & int_en);
    end
  end
endmodule

// ---- tb/csf_status_sva.sv ----
// Purpose: Port assertions for the status flag block.
// Assumes: Zero-wait bus and a registered ALU result.
// Notes:   Bound to csf_status_top.
`timescale 1ns/1ps
`include "csf_defs.vh"
module csf_status_sva (
  input wire logic       hclk,        // Clock.
  input wire logic       hresetn,     // Reset, low.
  input wire logic       hreadyout,   // Ready out.
  input wire logic       hresp,       // Response.
  input wire logic       op_valid,    // Op strobe.
  input wire logic [2:0] op_code,     // Op code.
  input wire logic [7:0] op_a,        // Operand a.
  input wire logic [7:0] op_b,        // Operand b.
  input wire logic [7:0] op_result,   // Result.
  input wire logic       wdog_clear,  // Clear pulse.
  input wire logic       sleep_instr, // Sleep pulse.
  input wire logic [7:0] bank_base,   // Bank base.
  input wire logic       wdog_reset   // Time-out.
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_op(logic [2:0] c); op_valid && op_code == c; endsequence
  // A restarted divider keeps the time-out away far longer than this.
  sequence s_quiet; !wdog_reset [*8]; endsequence
  property p_bus; hreadyout && !hresp; endproperty
  property p_bank; bank_base == `CSF_BANK0_BASE || bank_base == `CSF_BANK1_BASE; endproperty
  property p_add; s_op(`CSF_OP_ADD) |=> op_result == 8'($past(op_a) + $past(op_b)); endproperty
  property p_sub; s_op(`CSF_OP_SUB) |=> op_result == 8'($past(op_a) + ~$past(op_b) + 8'h01); endproperty
  property p_and; s_op(`CSF_OP_LOGIC) |=> op_result == ($past(op_a) & $past(op_b)); endproperty
  property p_hold; !op_valid |=> $stable(op_result); endproperty
  property p_pulse; wdog_reset |=> !wdog_reset; endproperty
  property p_restart; wdog_clear || sleep_instr |-> ##2 s_quiet; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
  a_bank: assert property (p_bank) else $error("bank base not a bank start");
  a_add: assert property (p_add) else $error("add result wrong");
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  a_and: assert property (p_and) else $error("logic result wrong");
  a_hold: assert property (p_hold) else $error("result moved without an op");
  a_pulse: assert property (p_pulse) else $error("time-out pulse too long");
  a_restart: assert property (p_restart) else $error("time-out soon after restart");
endmodule
bind csf_status_top csf_status_sva csf_status_sva_i (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_result(op_result),
  .wdog_clear(wdog_clear), .sleep_instr(sleep_instr), .bank_base(bank_base), .wdog_reset(wdog_reset));

// ---- tb/csf_status_top_test.sv ----
// Purpose: Self-checking bench for the status flag block.
// Assumes: Zero-wait bus slave, pulses one clock wide.
// Notes:   ALU table first, then hand tests.
`timescale 1ns/1ps
`include "csf_defs.vh"
module csf_status_top_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic        op_valid = 1'b0;
  logic [2:0]  op_code = 3'h7;
  logic [7:0]  op_a = 8'h00;
  logic [7:0]  op_b = 8'h00;
  logic        wdog_clear = 1'b0;
  logic        ext_pin = 1'b0;
  logic        sleep_instr = 1'b0;
  wire  [31:0] hrdata;
  wire  [7:0]  op_result;
  wire  [7:0]  bank_base;
  wire         hreadyout;
  wire         hresp;
  wire         wdog_reset;
  wire         irq;
  logic [31:0] rd;
  logic [7:0]  t1;
  int          failures = 0;
  int          checked = 0;
  int          n;
  // Row: code, a, b, result, zero nibble carry, result checked.
  logic [30:0] rows [0:10] = '{
    {`CSF_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'h2, 1'b1},
    {`CSF_OP_ADD, 8'hFF, 8'h01, 8'h00, 3'h7, 1'b1},
    {`CSF_OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7, 1'b1},
    {`CSF_OP_SUB, 8'h03, 8'h04, 8'hFF, 3'h0, 1'b1},
    {`CSF_OP_SUB, 8'h10, 8'h01, 8'h0F, 3'h1, 1'b1},
    {`CSF_OP_LOGIC, 8'hF0, 8'h0F, 8'h00, 3'h5, 1'b1},
    {`CSF_OP_ROTR, 8'hFE, 8'h00, 8'h00, 3'h4, 1'b0},
    {`CSF_OP_ROTL, 8'h80, 8'h00, 8'h00, 3'h5, 1'b0},
    {`CSF_OP_NONE, 8'h00, 8'h00, 8'h00, 3'h5, 1'b0},
    {`CSF_OP_ADD, 8'h22, 8'h33, 8'h55, 3'h0, 1'b1},
    {`CSF_OP_LOGIC, 8'hAC, 8'hF3, 8'hA0, 3'h0, 1'b1}};
  csf_status_top csf_status_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
    .op_result(op_result), .wdog_clear(wdog_clear), .sleep_instr(sleep_instr), .ext_tick_pin(ext_pin),
    .bank_base(bank_base), .wdog_reset(wdog_reset), .irq(irq));
  always #2.5 hclk = ~hclk;
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic alu(input logic [2:0] c, input logic [7:0] a, input logic [7:0] b);
    @(posedge hclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_a <= a;
    op_b <= b;
    @(posedge hclk);
    op_valid <= 1'b0;
  endtask
  task automatic pulse(input logic s, input logic c);
    @(posedge hclk);
    sleep_instr <= s;
    wdog_clear <= c;
    @(posedge hclk);
    sleep_instr <= 1'b0;
    wdog_clear <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      alu(rows[i][30:28], rows[i][27:20], rows[i][19:12]);
      #1;
      if (rows[i][0]) chk({24'h0, op_result}, {24'h0, rows[i][11:4]});
      rdchk(`CSF_OFF_STATUS, {29'h3, rows[i][3:1]});
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0);
    for (int k = 1; k >= 0; k--) begin
      bus(1'b1, `CSF_OFF_STATUS, k ? 32'h20 : 32'h0);
      @(posedge hclk);
      #1;
      chk({24'h0, bank_base}, k ? 32'h80 : 32'h0);
      rdchk(`CSF_OFF_STATUS, k ? 32'h38 : 32'h18);
    end
    pulse(1'b1, 1'b0);
    rdchk(`CSF_OFF_STATUS, 32'h10);
    pulse(1'b0, 1'b1);
    rdchk(`CSF_OFF_STATUS, 32'h18);
    alu(`CSF_OP_ADD, 8'hFF, 8'h01);
    pulse(1'b1, 1'b0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`CSF_OFF_STATUS, 32'h18);
    rdchk(`CSF_OFF_OPTION, 32'hFF);
    bus(1'b1, `CSF_OFF_OPTION, 32'h08);
    pulse(1'b0, 1'b1);
    n = 0;
    while (wdog_reset !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(32'(n >= 500 && n <= 520), 32'h1);
    rdchk(`CSF_OFF_STATUS, 32'h08);
    bus(1'b0, `CSF_OFF_INTSTAT, 32'h0);
    chk(rd & 32'h2, 32'h2);
    chk(32'(irq), 32'h0);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, k ? `CSF_OFF_INTCLR : `CSF_OFF_INTEN, 32'h2);
      @(posedge hclk);
      #1;
      chk(32'(irq), k ? 32'h0 : 32'h1);
    end
    pulse(1'b0, 1'b1);
    rdchk(`CSF_OFF_STATUS, 32'h18);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `CSF_OFF_OPTION, k ? 32'h00 : 32'h08);
      bus(1'b0, `CSF_OFF_TIMER, 32'h0);
      t1 = rd[7:0];
      repeat (13) @(posedge hclk);
      bus(1'b0, `CSF_OFF_TIMER, 32'h0);
      chk({24'h0, rd[7:0] - t1}, k ? 32'h8 : 32'h10);
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `CSF_OFF_OPTION, k ? 32'h38 : 32'h28);
      bus(1'b0, `CSF_OFF_TIMER, 32'h0);
      t1 = rd[7:0];
      repeat (3) begin
        @(posedge hclk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        ext_pin <= 1'b0;
        repeat (3) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
      bus(1'b0, `CSF_OFF_TIMER, 32'h0);
      chk({24'h0, rd[7:0] - t1}, 32'h3);
    end
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    stop_test();
  end
endmodule
